// >>> design/status_reg_map.vh
// Offsets, bit positions and reset values of the bus status flag register
// Overview of operation
// R01: Address or data parity error sets bit 15
// R02: Enabled system error signalled sets bit 14
// R03: Own cycle master abort sets bit 13
// R04: Own cycle target abort sets bit 12
// R05: Target abort we signalled sets bit 11
// R06: Device select timing reads fixed 01b
// R07: Bit 8 needs parity error, mastering, enable
// R08: Bit 7 reads zero, no fast back-to-back
// R09: Bit 6 reads zero, no user features
// R10: Bit 5 reads one, 66 MHz capable
// R11: Bit 4 reads one, capability list present
// R12: Bit 3 follows interrupt; INTx needs disable clear
// R13: Interrupt status updates whatever the disable bit
// R14: Bits 2 to 0 read zero
// R15: Disable bit one blocks the interrupt output
// R16: System error output only when enable set
// R17: Parity error output only when response enabled
// R18: Error flags clear on written one only
`ifndef STATUS_REG_MAP_VH
`define STATUS_REG_MAP_VH

// ----------------------------------------------------------------------
// Configuration space offsets
// ----------------------------------------------------------------------
`define CFG_CMD_OFFSET        8'h04
`define CFG_STATUS_OFFSET     8'h06

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define ST_PARITY_BIT         15
`define ST_SIGNALLED_SYSTEM_ERROR_FLAG_BIT        14
`define ST_RECEIVED_MASTER_ABORT_FLAG_BIT         13
`define ST_RECEIVED_TARGET_ABORT_FLAG_BIT     12
`define ST_SIGNALLED_TARGET_ABORT_FLAG_BIT     11
`define ST_DEVSEL_HI_BIT      10
`define ST_DEVSEL_LO_BIT      9
`define ST_MASTER_DATA_PARITY_FLAG_BIT        8
`define ST_FAST_B2B_BIT       7
`define ST_USER_FEAT_BIT      6
`define ST_HIGH_SPEED_BIT     5
`define ST_CAP_LIST_BIT       4
`define ST_INT_STATUS_BIT     3

// ----------------------------------------------------------------------
// Status register constants and reset value
// ----------------------------------------------------------------------
`define ST_DEVSEL_TIMING      2'h1
`define ST_FAST_B2B_VAL       1'h0
`define ST_USER_FEAT_VAL      1'h0
`define ST_HIGH_SPEED_VAL     1'h1
`define ST_CAP_LIST_VAL       1'h1
`define ST_RESERVED_LOW       3'h0
`define ST_RESET_VALUE        16'h0230

// ----------------------------------------------------------------------
// Command register bits used here
// ----------------------------------------------------------------------
`define CMD_INT_DISABLE_BIT   10
`define CMD_SERR_ENABLE_BIT   8
`define CMD_PARITY_RESP_BIT   6
`define CMD_RESET_VALUE       16'h0000

// ----------------------------------------------------------------------
// Flag bank layout: index of each sticky flag
// ----------------------------------------------------------------------
`define FLAG_COUNT            6
`define FLAG_PARITY           0
`define FLAG_SIGNALLED_SYSTEM_ERROR_FLAG          1
`define FLAG_RECEIVED_MASTER_ABORT_FLAG           2
`define FLAG_RECEIVED_TARGET_ABORT_FLAG       3
`define FLAG_SIGNALLED_TARGET_ABORT_FLAG       4
`define FLAG_MASTER_DATA_PARITY_FLAG          5
`define FLAG_RESET_VALUE      6'h00

`endif

// >>> design/sticky_flag_bank.v
// Bank of sticky error flags, set by hardware events, cleared by writing one
`timescale 1ns/100ps
`include "status_reg_map.vh"

module sticky_flag_bank (
  // Clock and synchronised reset
  input  wire                    i_clock,
  input  wire                    i_rst_n,
  // Event and clear strobes, one per flag
  input  wire [`FLAG_COUNT-1:0]  i_set,
  input  wire [`FLAG_COUNT-1:0]  i_clear,
  // Flag values
  output wire [`FLAG_COUNT-1:0]  o_flags
);

  reg  [`FLAG_COUNT-1:0] flags_q;
  wire [`FLAG_COUNT-1:0] flags_d;

  // ----------------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------------
  // Set wins over clear so an event in the clearing cycle is kept
  assign flags_d = i_set | (flags_q & ~i_clear);  // [R18]

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Flags hold until software clears them; reads leave them alone
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= `FLAG_RESET_VALUE;
    end else begin
      flags_q <= flags_d;  // [R18]
    end
  end

  assign o_flags = flags_q;

endmodule

// >>> design/pci_config_status_register.v
// Configuration status register with its error flags and bus signal gating
`timescale 1ns/100ps
`include "status_reg_map.vh"

module pci_config_status_register (
  // Clock and reset
  input  wire         i_clock,
  input  wire         i_resetn,
  // Configuration access port
  input  wire         i_cfg_read,
  input  wire         i_cfg_write,
  input  wire [7:0]   i_cfg_addr,
  input  wire [1:0]   i_cfg_byte_en,
  input  wire [15:0]  i_cfg_wdata,
  output reg  [15:0]  o_cfg_rdata,
  output reg          o_cfg_ack,
  // Bus events from the function's own bus logic
  input  wire         i_addr_parity_err,
  input  wire         i_data_parity_err,
  input  wire         i_serr_request,
  input  wire         i_master_abort,
  input  wire         i_target_abort_rcvd,
  input  wire         i_target_abort_sent,
  input  wire         i_bus_master,
  input  wire         i_int_condition,
  // Parity error pin as seen on the bus
  input  wire         i_perr_pin_n,
  // Open-drain interrupt pin
  output wire         o_intx_out,
  output wire         o_intx_oe_n,
  // Open-drain system error pin
  output wire         o_serr_out,
  output wire         o_serr_oe_n,
  // Parity error pin drive
  output wire         o_perr_out,
  output wire         o_perr_oe_n,
  // Live register contents for the rest of the function
  output wire [15:0]  o_status_value,
  output wire [15:0]  o_command_value
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Expand the two byte enables into a sixteen bit lane mask
  function [15:0] lane_mask;
    input [1:0] be;
    begin
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Compare a byte address against a half-word register offset
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr[7:1] == offset[7:1]);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg                     rst_meta_q;
  reg                     rst_sync_q;
  wire                    rst_n;

  reg                     perr_meta_q;
  reg                     perr_sync_q;
  reg                     master_dly1_q;
  reg                     master_dly2_q;
  wire                    perr_seen;

  reg                     int_disable_q;
  wire                    int_disable_d;
  reg                     serr_enable_q;
  reg                     parity_resp_q;
  reg                     int_status_q;

  reg                     intx_oe_n_q;
  reg                     serr_oe_n_q;
  reg                     perr_oe_n_q;

  wire                    cmd_hit;
  wire                    status_hit;
  wire [15:0]             wmask;
  wire [15:0]             clear_word;

  wire [`FLAG_COUNT-1:0]  flag_set;
  wire [`FLAG_COUNT-1:0]  flag_clear;
  wire [`FLAG_COUNT-1:0]  flags;

  wire                    serr_fire;
  wire                    perr_fire;

  reg  [15:0]             status_word;
  reg  [15:0]             command_word;
  reg  [15:0]             rdata_d;

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  // Asserts at once, releases two clock edges after the pin goes high
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'h0;
      rst_sync_q <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ----------------------------------------------------------------------
  // Parity error pin synchroniser
  // ----------------------------------------------------------------------
  // Any agent may drive the pin, so it is treated as asynchronous
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      perr_meta_q <= 1'h1;
      perr_sync_q <= 1'h1;
    end else begin
      perr_meta_q <= i_perr_pin_n;
      perr_sync_q <= perr_meta_q;
    end
  end

  // Master indication delayed to line up with the synchronised pin
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      master_dly1_q <= 1'h0;
      master_dly2_q <= 1'h0;
    end else begin
      master_dly1_q <= i_bus_master;
      master_dly2_q <= master_dly1_q;
    end
  end

  assign perr_seen = ~perr_sync_q;

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  // Only half-word offsets are compared; bit 0 of the address is ignored
  assign cmd_hit    = hit(i_cfg_addr, `CFG_CMD_OFFSET);
  assign status_hit = hit(i_cfg_addr, `CFG_STATUS_OFFSET);
  assign wmask      = lane_mask(i_cfg_byte_en);

  // Bits written as one on enabled lanes of a status write
  assign clear_word = (i_cfg_write && status_hit) ? (i_cfg_wdata & wmask) : 16'h0000;

  // ----------------------------------------------------------------------
  // Command register bits used by this block
  // ----------------------------------------------------------------------
  // Next disable value, so the pin mask takes effect with the write itself
  assign int_disable_d = (i_cfg_write && cmd_hit && wmask[`CMD_INT_DISABLE_BIT]) ?
                         i_cfg_wdata[`CMD_INT_DISABLE_BIT] : int_disable_q;  // [R15]

  // Other command bits belong elsewhere and are not stored here
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      int_disable_q <= 1'h0;
      serr_enable_q <= 1'h0;
      parity_resp_q <= 1'h0;
    end else if (i_cfg_write && cmd_hit) begin
      int_disable_q <= int_disable_d;
      if (wmask[`CMD_SERR_ENABLE_BIT]) begin
        serr_enable_q <= i_cfg_wdata[`CMD_SERR_ENABLE_BIT];
      end
      if (wmask[`CMD_PARITY_RESP_BIT]) begin
        parity_resp_q <= i_cfg_wdata[`CMD_PARITY_RESP_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------------
  // System error is only signalled with its driver enabled
  assign serr_fire = i_serr_request & serr_enable_q;  // [R16]
  // Parity error drive needs the response enable
  assign perr_fire = i_data_parity_err & parity_resp_q;  // [R17]

  assign flag_set[`FLAG_PARITY]     = i_addr_parity_err | i_data_parity_err;  // [R01]
  assign flag_set[`FLAG_SIGNALLED_SYSTEM_ERROR_FLAG]    = serr_fire;  // [R02]
  assign flag_set[`FLAG_RECEIVED_MASTER_ABORT_FLAG]     = i_master_abort;  // [R03]
  assign flag_set[`FLAG_RECEIVED_TARGET_ABORT_FLAG] = i_target_abort_rcvd;  // [R04]
  assign flag_set[`FLAG_SIGNALLED_TARGET_ABORT_FLAG] = i_target_abort_sent;  // [R05]
  // Pin seen, we were master, and response enabled
  assign flag_set[`FLAG_MASTER_DATA_PARITY_FLAG]    = perr_seen & master_dly2_q & parity_resp_q;  // [R07]

  // Write one to clear; zeros leave a flag as it is
  assign flag_clear[`FLAG_PARITY]     = clear_word[`ST_PARITY_BIT];  // [R18]
  assign flag_clear[`FLAG_SIGNALLED_SYSTEM_ERROR_FLAG]    = clear_word[`ST_SIGNALLED_SYSTEM_ERROR_FLAG_BIT];  // [R18]
  assign flag_clear[`FLAG_RECEIVED_MASTER_ABORT_FLAG]     = clear_word[`ST_RECEIVED_MASTER_ABORT_FLAG_BIT];  // [R18]
  assign flag_clear[`FLAG_RECEIVED_TARGET_ABORT_FLAG] = clear_word[`ST_RECEIVED_TARGET_ABORT_FLAG_BIT];  // [R18]
  assign flag_clear[`FLAG_SIGNALLED_TARGET_ABORT_FLAG] = clear_word[`ST_SIGNALLED_TARGET_ABORT_FLAG_BIT];  // [R18]
  assign flag_clear[`FLAG_MASTER_DATA_PARITY_FLAG]    = clear_word[`ST_MASTER_DATA_PARITY_FLAG_BIT];  // [R18]

  // ----------------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------------
  sticky_flag_bank u_flags (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .i_set   (flag_set),
    .i_clear (flag_clear),
    .o_flags (flags)
  );

  // ----------------------------------------------------------------------
  // Interrupt status and pin drive
  // ----------------------------------------------------------------------
  // Status tracks the condition whatever the disable bit says
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      int_status_q <= 1'h0;
    end else begin
      int_status_q <= i_int_condition;  // [R12] [R13]
    end
  end

  // Pin outputs registered so the bus never sees a decode glitch
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      intx_oe_n_q <= 1'h1;
      serr_oe_n_q <= 1'h1;
      perr_oe_n_q <= 1'h1;
    end else begin
      intx_oe_n_q <= ~(i_int_condition & ~int_disable_d);  // [R12] [R15]
      serr_oe_n_q <= ~serr_fire;  // [R16]
      perr_oe_n_q <= ~perr_fire;  // [R17]
    end
  end

  // Open-drain pins only ever pull low
  assign o_intx_out  = 1'h0;
  assign o_intx_oe_n = intx_oe_n_q;
  assign o_serr_out  = 1'h0;
  assign o_serr_oe_n = serr_oe_n_q;
  assign o_perr_out  = 1'h0;
  assign o_perr_oe_n = perr_oe_n_q;

  // ----------------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------------
  // Hardwired capability fields are built here, never stored
  always @* begin
    status_word = 16'h0000;
    status_word[`ST_PARITY_BIT]     = flags[`FLAG_PARITY];
    status_word[`ST_SIGNALLED_SYSTEM_ERROR_FLAG_BIT]    = flags[`FLAG_SIGNALLED_SYSTEM_ERROR_FLAG];
    status_word[`ST_RECEIVED_MASTER_ABORT_FLAG_BIT]     = flags[`FLAG_RECEIVED_MASTER_ABORT_FLAG];
    status_word[`ST_RECEIVED_TARGET_ABORT_FLAG_BIT] = flags[`FLAG_RECEIVED_TARGET_ABORT_FLAG];
    status_word[`ST_SIGNALLED_TARGET_ABORT_FLAG_BIT] = flags[`FLAG_SIGNALLED_TARGET_ABORT_FLAG];
    status_word[`ST_DEVSEL_HI_BIT:`ST_DEVSEL_LO_BIT] = `ST_DEVSEL_TIMING;  // [R06]
    status_word[`ST_MASTER_DATA_PARITY_FLAG_BIT]    = flags[`FLAG_MASTER_DATA_PARITY_FLAG];
    status_word[`ST_FAST_B2B_BIT]   = `ST_FAST_B2B_VAL;  // [R08]
    status_word[`ST_USER_FEAT_BIT]  = `ST_USER_FEAT_VAL;  // [R09]
    status_word[`ST_HIGH_SPEED_BIT] = `ST_HIGH_SPEED_VAL;  // [R10]
    status_word[`ST_CAP_LIST_BIT]   = `ST_CAP_LIST_VAL;  // [R11]
    status_word[`ST_INT_STATUS_BIT] = int_status_q;  // [R12]
    status_word[2:0]                = `ST_RESERVED_LOW;  // [R14]
  end

  // Command image holds only the three bits kept here
  always @* begin
    command_word = `CMD_RESET_VALUE;
    command_word[`CMD_INT_DISABLE_BIT] = int_disable_q;
    command_word[`CMD_SERR_ENABLE_BIT] = serr_enable_q;
    command_word[`CMD_PARITY_RESP_BIT] = parity_resp_q;
  end

  assign o_status_value  = status_word;
  assign o_command_value = command_word;

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Unmapped offsets and disabled lanes read as zero
  always @* begin
    rdata_d = 16'h0000;
    if (status_hit) begin
      rdata_d = status_word & wmask;
    end else if (cmd_hit) begin
      rdata_d = command_word & wmask;
    end
  end

  // ----------------------------------------------------------------------
  // Access answer
  // ----------------------------------------------------------------------
  // One-cycle acknowledge for every read or write, mapped or not
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_cfg_ack   <= 1'h0;
      o_cfg_rdata <= 16'h0000;
    end else begin
      o_cfg_ack <= i_cfg_read | i_cfg_write;
      if (i_cfg_read) begin
        o_cfg_rdata <= rdata_d;
      end
    end
  end

endmodule

// >>> verification/status_reg_props.sv
// Checker of the status register behaviour seen at the block's ports
`timescale 1ns/100ps
module status_reg_props (
  // Clock and reset
  input wire        i_clock,
  input wire        i_resetn,
  // Access port
  input wire        i_cfg_read,
  input wire        i_cfg_write,
  input wire [7:0]  i_cfg_addr,
  input wire [1:0]  i_cfg_byte_en,
  input wire [15:0] i_cfg_wdata,
  input wire        o_cfg_ack,
  // Bus events
  input wire        i_addr_parity_err,
  input wire        i_data_parity_err,
  input wire        i_serr_request,
  input wire        i_master_abort,
  input wire        i_int_condition,
  // Pin enables and register images
  input wire        o_intx_oe_n,
  input wire        o_serr_oe_n,
  input wire        o_perr_oe_n,
  input wire [15:0] o_status_value,
  input wire [15:0] o_command_value
);
  // ----------------------------------------------------------------
  // Assertions, all in the one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_ack_follows : assert property (
    (i_cfg_read || i_cfg_write) |=> o_cfg_ack) else $error("no ack after request");
  a_fixed_bits : assert property (
    o_status_value[10:9] == 2'h1 && o_status_value[7:4] == 4'h3
    && o_status_value[2:0] == 3'h0) else $error("hardwired status bits wrong");
  a_parity_sets : assert property (
    (i_addr_parity_err || i_data_parity_err) |=> o_status_value[15])
    else $error("parity flag not set");
  a_syserr_sets : assert property (
    (i_serr_request && o_command_value[8]) |=> o_status_value[14] && !o_serr_oe_n)
    else $error("system error not signalled");
  a_master_abort : assert property (
    i_master_abort |=> o_status_value[13]) else $error("master abort flag not set");
  a_serr_gated : assert property (
    !o_serr_oe_n |-> $past(i_serr_request && o_command_value[8]))
    else $error("system error pin driven while disabled");
  a_perr_gated : assert property (
    !o_perr_oe_n |-> $past(i_data_parity_err && o_command_value[6]))
    else $error("parity pin driven while disabled");
  a_data_parity_gate : assert property (
    $rose(o_status_value[8]) |-> $past(o_command_value[6]))
    else $error("master parity flag set without response enable");
  a_int_status : assert property (
    1'b1 |=> o_status_value[3] == $past(i_int_condition))
    else $error("interrupt status does not follow condition");
  a_intx_gate : assert property (
    1'b1 |=> o_intx_oe_n == !($past(i_int_condition) && !o_command_value[10]))
    else $error("interrupt pin drive wrong");
  a_flag_sticky : assert property (
    $fell(o_status_value[13]) |-> $past(i_cfg_write && i_cfg_byte_en[1]
    && i_cfg_wdata[13] && i_cfg_addr[7:1] == 7'h03)) else $error("flag lost without clear");

  // Main scenarios reached
  c_status_read : cover property (i_cfg_read && i_cfg_addr == 8'h06 ##1 o_cfg_ack);
  c_data_parity : cover property ($rose(o_status_value[8]));
  c_int_masked  : cover property (o_status_value[3] && o_command_value[10]);
endmodule

bind pci_config_status_register status_reg_props u_props (
  .i_clock, .i_resetn, .i_cfg_read, .i_cfg_write, .i_cfg_addr, .i_cfg_byte_en,
  .i_cfg_wdata, .o_cfg_ack, .i_addr_parity_err, .i_data_parity_err, .i_serr_request,
  .i_master_abort, .i_int_condition, .o_intx_oe_n, .o_serr_oe_n, .o_perr_oe_n,
  .o_status_value, .o_command_value
);

// >>> verification/pci_bus_agent.sv
// Bus side model: pull-ups on the open-drain lines and a foreign parity error driver
`timescale 1ns/100ps
module pci_bus_agent (
  // Drive requests from both sides
  input  wire i_pull_perr,
  input  wire i_perr_oe_n,
  input  wire i_serr_oe_n,
  input  wire i_intx_oe_n,
  // Levels driven while an enable is low
  input  wire i_perr_out,
  input  wire i_serr_out,
  input  wire i_intx_out,
  // Resolved wire levels
  output wire o_perr_n,
  output wire o_serr_n,
  output wire o_intx_n
);
  // Released lines float to the pull-up level, any driver wins low
  assign o_perr_n = i_pull_perr ? 1'b0 : (i_perr_oe_n ? 1'b1 : i_perr_out);
  assign o_serr_n = i_serr_oe_n ? 1'b1 : i_serr_out;
  assign o_intx_n = i_intx_oe_n ? 1'b1 : i_intx_out;
endmodule

// >>> verification/pci_config_status_register_tb.sv
// Self-checking bench for the configuration status register
`timescale 1ns/100ps
module pci_config_status_register_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [1:0]  be = 2'h0;
  reg  [15:0] wdata = 16'h0000;
  reg  [5:0]  ev = 6'h00;
  reg         bm = 1'b0;
  reg         icond = 1'b0;
  reg         pull = 1'b0;
  reg  [15:0] got;
  reg  [15:0] m;
  reg  [2:0]  pins;
  wire [15:0] rdata;
  wire        ack;
  wire        intx_oe_n;
  wire        serr_oe_n;
  wire        perr_oe_n;
  wire        perr_n;
  wire        serr_n;
  wire        intx_n;
  wire        perr_out;
  wire        serr_out;
  wire        intx_out;
  integer     errors = 0;
  integer     comparisons = 0;
  integer     i;

  // ----------------------------------------------------------------
  // Clock, design and bus side
  // ----------------------------------------------------------------
  initial forever #2 clk = ~clk;

  pci_config_status_register DUT (
    .i_clock(clk), .i_resetn(rst_n), .i_cfg_read(rd), .i_cfg_write(wr),
    .i_cfg_addr(addr), .i_cfg_byte_en(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .o_cfg_ack(ack), .i_addr_parity_err(ev[0]), .i_data_parity_err(ev[1]),
    .i_serr_request(ev[2]), .i_master_abort(ev[3]), .i_target_abort_rcvd(ev[4]),
    .i_target_abort_sent(ev[5]), .i_bus_master(bm), .i_int_condition(icond),
    .i_perr_pin_n(perr_n), .o_intx_out(intx_out), .o_intx_oe_n(intx_oe_n),
    .o_serr_out(serr_out), .o_serr_oe_n(serr_oe_n), .o_perr_out(perr_out),
    .o_perr_oe_n(perr_oe_n),
    .o_status_value(), .o_command_value());

  pci_bus_agent u_bus (.i_pull_perr(pull), .i_perr_oe_n(perr_oe_n), .i_serr_oe_n(serr_oe_n),
    .i_intx_oe_n(intx_oe_n), .i_perr_out(perr_out), .i_serr_out(serr_out),
    .i_intx_out(intx_out), .o_perr_n(perr_n), .o_serr_n(serr_n), .o_intx_n(intx_n));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // One access; ack and data are sampled just after the answering edge
  task acc(input w, input [7:0] a, input [1:0] b, input [15:0] d);
    begin
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      be <= b;
      wdata <= d;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      #1 chk({15'h0, ack}, 16'h0001);
      got = rdata;
    end
  endtask

  task rchk(input [7:0] a, input [15:0] exp);
    begin
      acc(1'b0, a, 2'h3, 16'h0000);
      chk(got, exp);
    end
  endtask

  // One-cycle event pulse; pins captured in the cycle they answer
  task pulse(input [5:0] v);
    begin
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 6'h00;
      #1 pins = {perr_n, serr_n, intx_n};
    end
  endtask

  // Another agent pulls the parity line for one cycle
  task foreign_perr(input master);
    begin
      @(posedge clk);
      bm <= master;
      pull <= 1'b1;
      @(posedge clk);
      pull <= 1'b0;
      repeat (4) @(posedge clk);
      bm <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset_values;
    begin
      rchk(8'h06, 16'h0230);
      rchk(8'h04, 16'h0000);
      rchk(8'h08, 16'h0000);
      acc(1'b0, 8'h07, 2'h1, 16'h0000);
      chk(got, 16'h0030);
      acc(1'b1, 8'h06, 2'h3, 16'h06CF);
      rchk(8'h06, 16'h0230);
    end
  endtask

  // Each event sets its flag; only a written one on the enabled lane clears it
  task t_error_flags;
    begin
      acc(1'b1, 8'h04, 2'h3, 16'h0100);
      for (i = 0; i < 6; i = i + 1) begin
        m = (i < 2) ? 16'h8000 : (16'h8000 >> (i - 1));
        pulse(6'h01 << i);
        chk({13'h0, pins}, (i == 2) ? 16'h0005 : 16'h0007);
        rchk(8'h06, 16'h0230 | m);
        acc(1'b1, 8'h06, 2'h1, 16'hFFFF);
        acc(1'b1, 8'h06, 2'h3, 16'h0000);
        rchk(8'h06, 16'h0230 | m);
        acc(1'b1, 8'h06, 2'h3, m);
        rchk(8'h06, 16'h0230);
      end
      acc(1'b1, 8'h04, 2'h3, 16'h0000);
      pulse(6'h04);
      chk({13'h0, pins}, 16'h0007);
      rchk(8'h06, 16'h0230);
      acc(1'b1, 8'h04, 2'h3, 16'h0040);
      pulse(6'h02);
      chk({13'h0, pins}, 16'h0003);
      acc(1'b1, 8'h06, 2'h3, 16'h8000);
    end
  endtask

  task t_data_parity;
    begin
      acc(1'b1, 8'h04, 2'h3, 16'h0000);
      foreign_perr(1'b1);
      rchk(8'h06, 16'h0230);
      acc(1'b1, 8'h04, 2'h3, 16'h0040);
      foreign_perr(1'b0);
      rchk(8'h06, 16'h0230);
      foreign_perr(1'b1);
      rchk(8'h06, 16'h0330);
      acc(1'b1, 8'h06, 2'h3, 16'h0100);
      rchk(8'h06, 16'h0230);
    end
  endtask

  // Status follows the condition; the disable bit masks only the pin
  task t_interrupt;
    begin
      @(posedge clk);
      icond <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({15'h0, intx_n}, 16'h0000);
      rchk(8'h06, 16'h0238);
      acc(1'b1, 8'h04, 2'h3, 16'h0400);
      @(posedge clk);
      #1 chk({15'h0, intx_n}, 16'h0001);
      rchk(8'h06, 16'h0238);
      rchk(8'h04, 16'h0400);
      @(posedge clk);
      icond <= 1'b0;
      rchk(8'h06, 16'h0230);
      acc(1'b1, 8'h04, 2'h3, 16'h0000);
      chk({15'h0, intx_n}, 16'h0001);
    end
  endtask

  // ----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task final_report;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_values;
    t_error_flags;
    t_data_parity;
    t_interrupt;
    final_report;
  end

  // The run needs well under a thousand cycles
  initial begin
    #20000;
    errors = errors + 1;
    final_report;
  end
endmodule
